// >>> pkg/twah_pkg.sv
// Operation
// (R1) Masked address bits are ignored in match
// (R2) Mask resets zero, bit zero reads zero
// (R3) Completion flag set after every bus event except STOP; the code sets no flag for a received slave address that it does not ack
// (R4) Interrupt needs local and global enable; masked event bits raise irq without either enable
// (R5) Status code valid whenever flag set
// (R6) Writing one to flag bit clears it
// (R7) No operation while flag set, then start
// (R8) START sent sets flag with start code
// (R9) Address sent sets flag, code shows ack
// (R10) Data sent sets flag, code shows ack
// (R11) STOP request sends STOP, no flag after
// (R12) Clock line held low while flag set
// (R13) Software loads address into data register
// (R14) Software checks status code after steps
// (R15) Software updates registers before clearing flag
// (R16) Status code in upper five bits
// (R17) Data write with flag low sets collision
package twah_pkg;

	localparam logic [7:0] ADR_CTRL   = 8'h00;
	localparam logic [7:0] ADR_STATUS = 8'h04;
	localparam logic [7:0] ADR_DATA   = 8'h08;
	localparam logic [7:0] ADR_OWN    = 8'h0C;
	localparam logic [7:0] ADR_MASK   = 8'h10;
	localparam logic [7:0] ADR_EVT    = 8'h14;
	localparam logic [7:0] ADR_EVTMSK = 8'h18;
	localparam logic [7:0] ADR_GIE    = 8'h1C;

	localparam int CTL_FLAG = 7;
	localparam int CTL_ACK  = 6;
	localparam int CTL_STA  = 5;
	localparam int CTL_STO  = 4;
	localparam int CTL_EN   = 2;
	localparam int CTL_IE   = 0;

	localparam int EV_DONE = 0;
	localparam int EV_WCOL = 1;
	localparam int EV_STOP = 2;

	localparam logic [4:0] RST_CODE = 5'h1F;
	localparam logic [7:0] RST_DATA = 8'hFF;
	localparam logic [6:0] RST_OWN  = 7'h7F;
	localparam logic [6:0] RST_MASK = 7'h00;

	localparam logic [4:0] CODE_START  = 5'h01;
	localparam logic [4:0] CODE_RSTART = 5'h02;
	localparam logic [4:0] CODE_AW_ACK = 5'h03;
	localparam logic [4:0] CODE_AW_NAK = 5'h04;
	localparam logic [4:0] CODE_DW_ACK = 5'h05;
	localparam logic [4:0] CODE_DW_NAK = 5'h06;
	localparam logic [4:0] CODE_AR_ACK = 5'h08;
	localparam logic [4:0] CODE_AR_NAK = 5'h09;
	localparam logic [4:0] CODE_SW_OWN = 5'h0C;
	localparam logic [4:0] CODE_SW_GC  = 5'h0E;

	localparam logic [9:0] QTR_BASE_CYC = 10'h008;
	localparam logic [3:0] BITS_BYTE    = 4'h8;

	typedef enum logic [6:0] {
		S_IDLE  = 7'h01,
		S_START = 7'h02,
		S_BIT   = 7'h04,
		S_WAIT  = 7'h08,
		S_STOP  = 7'h10,
		S_SADR  = 7'h20,
		S_SACK  = 7'h40
	} twah_state_t;

	typedef struct packed {
		logic scl;
		logic sda;
	} twah_pin_in_t;

	typedef struct packed {
		logic scl_o;
		logic scl_oe;
		logic sda_o;
		logic sda_oe;
	} twah_pin_out_t;

	typedef struct packed {
		logic       flag;
		logic       ack_en;
		logic       sta;
		logic       sto;
		logic       wcol;
		logic       en;
		logic       ie;
		logic [4:0] code;
		logic [1:0] presc;
		logic [7:0] data;
		logic [6:0] own;
		logic       gce;
		logic [6:0] mask;
		logic [2:0] evt;
		logic [2:0] evt_mask;
		logic       gie;
	} twah_regs_t;

	typedef struct packed {
		twah_regs_t    r;
		twah_state_t   fsm;
		logic          mst;
		logic          adr;
		logic          busy;
		logic [9:0]    cnt;
		logic [1:0]    ph;
		logic [3:0]    bitn;
		logic [7:0]    shft;
		logic          ack_in;
		logic          scl_prev;
		logic          sda_prev;
		logic          pready;
		logic          pslverr;
		logic [31:0]   prdata;
		twah_pin_out_t pins;
		logic          irq;
	} twah_st_t;

endpackage : twah_pkg

// >>> verilog/twah_sync.sv
`timescale 1ns/1ps
`default_nettype none
module twah_sync #(
	parameter int W = 2
) (
	input  wire logic         ref_clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} twah_sync_st_t;

	twah_sync_st_t s_r;
	twah_sync_st_t s_nxt;

	always_comb begin
		s_nxt    = s_r;
		s_nxt.s1 = d_i;
		s_nxt.s2 = s_r.s1;
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			s_r <= '1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign q_o = s_r.s2;
endmodule : twah_sync
`default_nettype wire

// >>> verilog/twah_match.sv
`timescale 1ns/1ps
`default_nettype none
module twah_match (
	input  wire logic [6:0] rx_addr_i,
	input  wire logic [6:0] own_i,
	input  wire logic [6:0] mask_i,
	input  wire logic       gce_i,
	output logic            own_hit_o,
	output logic            gc_hit_o
);
	always_comb begin
		// (R1) masked bits dropped
		own_hit_o = ~|((rx_addr_i ^ own_i) & ~mask_i);
		gc_hit_o  = gce_i & (rx_addr_i == 7'h00);
	end
endmodule : twah_match
`default_nettype wire

// >>> verilog/twah_top.sv
`timescale 1ns/1ps
`default_nettype none
module twah_top
	import twah_pkg::*;
(
	input  wire logic                    ref_clk_i,
	input  wire logic                    rst_i,
	input  wire logic                    psel_i,
	input  wire logic                    penable_i,
	input  wire logic                    pwrite_i,
	input  wire logic [7:0]              paddr_i,
	input  wire logic [31:0]             pwdata_i,
	output logic      [31:0]             prdata_o,
	output logic                         pready_o,
	output logic                         pslverr_o,
	input  wire twah_pkg::twah_pin_in_t  pins_i,
	output twah_pkg::twah_pin_out_t      pins_o,
	output logic                         irq_o
);
	import twah_pkg::*;

	twah_st_t   s;
	twah_st_t   n;
	logic [1:0] bus_s;
	logic       scl_s;
	logic       sda_s;
	logic       own_hit;
	logic       gc_hit;
	logic       acc;
	logic       wr;
	logic       hit;
	logic [7:0] rd_val;
	logic [9:0] qtr;
	logic       tick;
	logic       scl_rise;
	logic       scl_fall;
	logic       bus_start;
	logic       bus_stop;
	logic       byte_done;

	twah_sync #(.W(2)) u_sync (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.d_i       ({pins_i.scl, pins_i.sda}),
		.q_o       (bus_s)
	);

	assign scl_s = bus_s[1];
	assign sda_s = bus_s[0];

	twah_match u_match (
		.rx_addr_i (s.shft[7:1]),
		.own_i     (s.r.own),
		.mask_i    (s.r.mask),
		.gce_i     (s.r.gce),
		.own_hit_o (own_hit),
		.gc_hit_o  (gc_hit)
	);

	always_comb begin
		acc       = psel_i & penable_i;
		wr        = acc & s.pready & pwrite_i;
		scl_rise  = scl_s & ~s.scl_prev;
		scl_fall  = ~scl_s & s.scl_prev;
		bus_start = scl_s & s.scl_prev & s.sda_prev & ~sda_s;
		bus_stop  = scl_s & s.scl_prev & ~s.sda_prev & sda_s;
		qtr       = QTR_BASE_CYC << {s.r.presc, 1'b0};
		tick      = (s.cnt == 10'h000);
		byte_done = tick & (s.ph == 2'h3) & (s.bitn == BITS_BYTE);
		hit       = 1'b1;
		rd_val    = 8'h00;
		unique case (paddr_i)
			ADR_CTRL: rd_val = {s.r.flag, s.r.ack_en, s.r.sta, s.r.sto,
				s.r.wcol, s.r.en, 1'b0, s.r.ie};
			// (R16) code in upper bits
			ADR_STATUS: rd_val = {s.r.code, 1'b0, s.r.presc};
			ADR_DATA:   rd_val = s.r.data;
			ADR_OWN:    rd_val = {s.r.own, s.r.gce};
			// (R2) low bit zero
			ADR_MASK:   rd_val = {s.r.mask, 1'b0};
			ADR_EVT:    rd_val = {5'h00, s.r.evt};
			ADR_EVTMSK: rd_val = {5'h00, s.r.evt_mask};
			ADR_GIE:    rd_val = {7'h00, s.r.gie};
			default:    hit = 1'b0;
		endcase
	end

	always_comb begin
		n          = s;
		n.pready   = 1'b0;
		n.pslverr  = 1'b0;
		n.scl_prev = scl_s;
		n.sda_prev = sda_s;
		if (acc & ~s.pready) begin
			n.pready  = 1'b1;
			n.pslverr = ~hit;
			n.prdata  = {24'h000000, rd_val};
		end
		if (wr) begin
			unique case (paddr_i)
				ADR_CTRL: begin
					n.r.ack_en = pwdata_i[CTL_ACK];
					n.r.sta    = pwdata_i[CTL_STA];
					n.r.sto    = pwdata_i[CTL_STO];
					n.r.en     = pwdata_i[CTL_EN];
					n.r.ie     = pwdata_i[CTL_IE];
					// (R6) write one clears
					if (pwdata_i[CTL_FLAG]) begin
						n.r.flag = 1'b0;
					end
				end
				ADR_STATUS: n.r.presc = pwdata_i[1:0];
				ADR_DATA: begin
					// (R17) collision flag
					if (s.r.flag) begin
						n.r.data = pwdata_i[7:0];
						n.r.wcol = 1'b0;
					end else begin
						n.r.wcol         = 1'b1;
						n.r.evt[EV_WCOL] = 1'b1;
					end
				end
				ADR_OWN: begin
					n.r.own = pwdata_i[7:1];
					n.r.gce = pwdata_i[0];
				end
				// (R2) low bit dropped
				ADR_MASK:   n.r.mask = pwdata_i[7:1];
				ADR_EVT:    n.r.evt = s.r.evt & ~pwdata_i[2:0];
				ADR_EVTMSK: n.r.evt_mask = pwdata_i[2:0];
				ADR_GIE:    n.r.gie = pwdata_i[0];
				default:    n.r = n.r;
			endcase
		end
		if (bus_start) begin
			n.busy = 1'b1;
		end else if (bus_stop) begin
			n.busy = 1'b0;
		end
		if (s.fsm == S_START || s.fsm == S_BIT || s.fsm == S_STOP) begin
			if (tick) begin
				n.cnt = qtr - 10'h001;
				n.ph  = s.ph + 2'h1;
			end else if (!(s.ph == 2'h1 && ~s.pins.scl_oe && ~scl_s)) begin
				n.cnt = s.cnt - 10'h001;
			end
		end else if (s.fsm != S_SACK) begin
			// Slave ack keeps its own phase
			n.cnt = qtr - 10'h001;
			n.ph  = 2'h0;
		end
		unique case (s.fsm)
			S_IDLE: begin
				n.pins.scl_oe = 1'b0;
				n.pins.sda_oe = 1'b0;
				n.mst         = 1'b0;
				// (R7) wait for clear flag
				if (s.r.en & s.r.sta & ~s.r.flag & ~s.busy) begin
					n.fsm = S_START;
				end else if (s.r.en & bus_start) begin
					n.fsm  = S_SADR;
					n.bitn = 4'h0;
				end
			end
			S_START: if (tick) begin
				unique case (s.ph)
					2'h0: n.pins.sda_oe = 1'b0;
					2'h1: n.pins.scl_oe = 1'b0;
					2'h2: n.pins.sda_oe = 1'b1;
					2'h3: begin
						n.pins.scl_oe = 1'b1;
						// (R8) start done
						n.r.flag = 1'b1;
						n.r.code = s.mst ? CODE_RSTART : CODE_START;
						n.mst    = 1'b1;
						n.adr    = 1'b1;
						n.fsm    = S_WAIT;
					end
				endcase
			end
			S_BIT: if (tick) begin
				unique case (s.ph)
					2'h0: begin
						n.pins.scl_oe = 1'b1;
						n.pins.sda_oe = (s.bitn != BITS_BYTE) & ~s.shft[7];
					end
					2'h1: n.pins.scl_oe = 1'b0;
					2'h2: begin
						if (s.bitn != BITS_BYTE) begin
							n.shft = {s.shft[6:0], sda_s};
						end else begin
							n.ack_in = sda_s;
						end
					end
					2'h3: begin
						n.pins.scl_oe = 1'b1;
						n.bitn        = s.bitn + 4'h1;
						if (s.bitn == BITS_BYTE) begin
							// (R3) byte done
							n.r.flag = 1'b1;
							n.r.data = s.shft;
							n.adr    = 1'b0;
							n.fsm    = S_WAIT;
							if (s.adr & ~s.shft[0]) begin
								// (R9) address with ack
								n.r.code = s.ack_in ? CODE_AW_NAK : CODE_AW_ACK;
							end else if (s.adr) begin
								n.r.code = s.ack_in ? CODE_AR_NAK : CODE_AR_ACK;
							end else begin
								// (R10) data with ack
								n.r.code = s.ack_in ? CODE_DW_NAK : CODE_DW_ACK;
							end
						end
					end
				endcase
			end
			S_WAIT: begin
				// (R12) hold clock low
				n.pins.scl_oe = s.r.flag | s.mst;
				// (R7) launch after clear
				if (~s.r.flag) begin
					if (~s.mst) begin
						n.pins.scl_oe = 1'b0;
						n.pins.sda_oe = 1'b0;
						n.fsm         = S_IDLE;
					end else if (s.r.sta) begin
						n.fsm = S_START;
					end else if (s.r.sto) begin
						n.fsm = S_STOP;
					end else begin
						n.fsm  = S_BIT;
						n.bitn = 4'h0;
						n.shft = s.r.data;
					end
				end
			end
			S_STOP: if (tick) begin
				unique case (s.ph)
					2'h0: begin
						n.pins.scl_oe = 1'b1;
						n.pins.sda_oe = 1'b1;
					end
					2'h1: n.pins.scl_oe = 1'b0;
					2'h2: n.pins.sda_oe = 1'b0;
					2'h3: begin
						// (R11) no flag after stop
						n.r.sto          = 1'b0;
						n.r.evt[EV_STOP] = 1'b1;
						n.mst            = 1'b0;
						n.fsm            = S_IDLE;
					end
				endcase
			end
			S_SADR: begin
				if (bus_stop) begin
					n.fsm = S_IDLE;
				end else if (scl_rise) begin
					n.shft = {s.shft[6:0], sda_s};
					n.bitn = s.bitn + 4'h1;
					if (s.bitn == BITS_BYTE - 4'h1) begin
						n.fsm = S_SACK;
					end
				end
			end
			S_SACK: begin
				if (s.ph == 2'h0 && scl_fall) begin
					// (R1) address compare
					if (s.r.ack_en & ~s.shft[0] & (own_hit | gc_hit)) begin
						n.pins.sda_oe = 1'b1;
						n.ph          = 2'h1;
					end else begin
						n.fsm = S_IDLE;
					end
				end else if (s.ph == 2'h1 && scl_rise) begin
					n.ph = 2'h2;
				end else if (s.ph == 2'h2 && scl_fall) begin
					n.pins.sda_oe = 1'b0;
					n.pins.scl_oe = 1'b1;
					// (R5) code with flag
					n.r.flag = 1'b1;
					n.r.code = own_hit ? CODE_SW_OWN : CODE_SW_GC;
					n.r.data = s.shft;
					n.mst    = 1'b0;
					n.fsm    = S_WAIT;
				end
			end
		endcase
		if (~s.r.en) begin
			n.fsm         = S_IDLE;
			n.pins.scl_oe = 1'b0;
			n.pins.sda_oe = 1'b0;
		end
		if (n.r.flag & ~s.r.flag) begin
			n.r.evt[EV_DONE] = 1'b1;
		end
		// (R4) flag irq needs both enables; masked events do not
		n.irq = (s.r.flag & s.r.ie & s.r.gie) | |(s.r.evt & s.r.evt_mask);
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			s        <= '0;
			s.fsm    <= S_IDLE;
			s.r.code <= RST_CODE;
			s.r.data <= RST_DATA;
			s.r.own  <= RST_OWN;
			// (R2) mask resets zero
			s.r.mask <= RST_MASK;
			s.scl_prev <= 1'b1;
			s.sda_prev <= 1'b1;
		end else begin
			s <= n;
		end
	end

	assign prdata_o  = s.prdata;
	assign pready_o  = s.pready;
	assign pslverr_o = s.pslverr;
	assign pins_o    = s.pins;
	assign irq_o     = s.irq;

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	AST_MASK_LSB: assert property ( // (R2)
		(pready_o && paddr_i == ADR_MASK) |-> prdata_o[0] == 1'b0)
		else $error("mask low bit read nonzero");
	AST_NO_LAUNCH: assert property ( // (R7)
		(s.fsm == S_WAIT && s.r.flag && !(wr && paddr_i == ADR_CTRL))
		|=> s.fsm == S_WAIT)
		else $error("operation began while flag set");
	AST_CLEAR_LAUNCH: assert property ( // (R6)
		(s.fsm == S_WAIT && s.mst && s.r.en && wr && paddr_i == ADR_CTRL
			&& pwdata_i[CTL_FLAG] && pwdata_i[CTL_EN])
		|=> !s.r.flag ##1 s.fsm != S_WAIT)
		else $error("flag clear did not launch");
	AST_STRETCH: assert property ( // (R12)
		(s.fsm == S_WAIT && s.r.flag) |-> s.pins.scl_oe)
		else $error("clock released while flag set");
	AST_IRQ: assert property ( // (R4)
		(s.r.flag && !(s.r.ie && s.r.gie) && !(|(s.r.evt & s.r.evt_mask)))
		|=> !irq_o)
		else $error("interrupt without enables");
	AST_STOP_NOFLAG: assert property ( // (R11)
		(s.fsm == S_STOP && !s.r.flag ##1 s.fsm == S_IDLE) |-> !s.r.flag)
		else $error("flag set after stop");
	AST_START_CODE: assert property ( // (R8)
		(s.fsm == S_START ##1 s.fsm == S_WAIT) |->
		s.r.flag && (s.r.code == CODE_START || s.r.code == CODE_RSTART))
		else $error("start code wrong");
	AST_ADDR_CODE: assert property ( // (R9)
		(s.fsm == S_BIT && s.adr && !s.shft[0] && byte_done) |=>
		s.r.flag && s.r.code == ($past(s.ack_in) ? CODE_AW_NAK : CODE_AW_ACK))
		else $error("address code wrong");
	AST_DATA_CODE: assert property ( // (R10)
		(s.fsm == S_BIT && !s.adr && byte_done) |=>
		s.r.flag && s.r.code == ($past(s.ack_in) ? CODE_DW_NAK : CODE_DW_ACK))
		else $error("data code wrong");
	AST_WCOL: assert property ( // (R17)
		(wr && paddr_i == ADR_DATA && !s.r.flag) |=> s.r.wcol)
		else $error("collision not flagged");

	COV_START: cover property (s.fsm == S_START ##1 s.fsm == S_WAIT);
	COV_BYTE: cover property (s.fsm == S_BIT && byte_done);
	COV_STOP: cover property (s.fsm == S_STOP ##1 s.fsm == S_IDLE);
	COV_SLAVE: cover property (s.fsm == S_SACK ##1 s.fsm == S_WAIT);
endmodule : twah_top
`default_nettype wire

// >>> test/twah_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
module twah_slave_model #(
	parameter logic [6:0] ADDR = 7'h2A
) (
	input  wire logic scl_i,
	input  wire logic sda_i,
	input  wire logic nak_i,
	output logic      sda_oe_o
);
	int         n;
	logic [7:0] sh;
	logic       first;
	logic       sel;
	initial begin
		sda_oe_o = 1'b0;
		n = 10;
		first = 1'b0;
		sel = 1'b0;
		sh = 8'h00;
	end
	always @(negedge sda_i) begin
		#1;
		if (scl_i === 1'b1) begin
			n = 0;
			first = 1'b1;
		end
	end
	always @(posedge sda_i) begin
		#1;
		if (scl_i === 1'b1) n = 10;
	end
	always @(posedge scl_i) begin
		if (n < 8) begin
			sh = {sh[6:0], sda_i};
			n = n + 1;
		end
	end
	always @(negedge scl_i) begin
		if (n == 9) begin
			sda_oe_o = 1'b0;
			n = 0;
		end else if (n == 8) begin
			if (first) sel = (sh[7:1] == ADDR);
			sda_oe_o = sel && (first || !nak_i);
			first = 1'b0;
			n = 9;
		end
	end
endmodule : twah_slave_model
`default_nettype wire

// >>> test/test_twah_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_twah_top;
	import twah_pkg::*;
	localparam logic [6:0] SADR = 7'h2A;
	logic          ref_clk, lclk, rst, psel, penable, pwrite;
	logic          pready, pslverr, irq, tscl, tsda, nak, m_oe, rerr;
	logic          scl_w, sda_w, ack;
	logic [7:0]    paddr, dat;
	logic [6:0]    own, msk, hit;
	logic [31:0]   pwdata, prdata, rdat;
	logic [7:0]    exp_q[$];
	twah_pin_in_t  pin;
	twah_pin_out_t pout;
	int            num_errors, comparisons, seed;
	logic [7:0]    ra[6];
	logic [7:0]    rv[6];
	assign scl_w = !(pout.scl_oe | tscl);
	assign sda_w = !(pout.sda_oe | tsda | m_oe);
	assign pin = {scl_w, sda_w};
	twah_top i_twah_top (
		.ref_clk_i (ref_clk),
		.rst_i     (rst),
		.psel_i    (psel),
		.penable_i (penable),
		.pwrite_i  (pwrite),
		.paddr_i   (paddr),
		.pwdata_i  (pwdata),
		.prdata_o  (prdata),
		.pready_o  (pready),
		.pslverr_o (pslverr),
		.pins_i    (pin),
		.pins_o    (pout),
		.irq_o     (irq)
	);
	twah_slave_model #(.ADDR(SADR)) i_twah_slave_model (
		.scl_i    (scl_w),
		.sda_i    (sda_w),
		.nak_i    (nak),
		.sda_oe_o (m_oe)
	);
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	initial begin
		lclk = 1'b0;
		forever #32 lclk = ~lclk;
	end
	task automatic test_done;
		$display("comparisons %0d errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : test_done
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge ref_clk);
			if (pready === 1'b1) break;
		end
		if (k == 20) begin
			num_errors++;
			test_done;
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rdat, e);
	endtask : rd
	task automatic irqchk(input logic e);
		repeat (2) @(posedge ref_clk);
		chk({31'h0, irq}, {31'h0, e});
	endtask : irqchk
	task automatic wflag;
		for (int k = 0; k < 300; k++) begin
			apb(1'b0, ADR_CTRL, 32'h0);
			if (rdat[CTL_FLAG] === 1'b1) return;
		end
		num_errors++;
		test_done;
	endtask : wflag
	task automatic step(input logic [7:0] c);
		apb(1'b1, ADR_CTRL, {24'h0, c});
		wflag;
		chk({31'h0, scl_w}, 32'h0);
		rd(ADR_STATUS, {24'h0, exp_q.pop_front()});
	endtask : step
	task automatic lk(input logic neg);
		if (neg) @(negedge lclk);
		else @(posedge lclk);
		@(posedge ref_clk);
	endtask : lk
	task automatic bang(input logic [7:0] b, output logic a);
		logic [8:0] x;
		x = {b, 1'b1};
		lk(1'b0);
		tsda <= 1'b1;
		for (int i = 8; i >= 0; i--) begin
			lk(1'b1);
			tscl <= 1'b1;
			tsda <= !x[i];
			lk(1'b0);
			tscl <= 1'b0;
		end
		lk(1'b1);
		a = (sda_w === 1'b0);
		tscl <= 1'b1;
		tsda <= 1'b1;
		repeat (4) @(posedge ref_clk);
	endtask : bang
	task automatic stopb;
		lk(1'b0);
		tscl <= 1'b0;
		lk(1'b1);
		tsda <= 1'b0;
	endtask : stopb
	initial begin
		ra = '{ADR_CTRL, ADR_STATUS, ADR_DATA, ADR_OWN, ADR_MASK, ADR_EVT};
		rv = '{8'h00, {RST_CODE, 3'h0}, RST_DATA, {RST_OWN, 1'b0},
			{RST_MASK, 1'b0}, 8'h00};
		{rst, psel, penable, pwrite, tscl, tsda} = 6'h20;
		{paddr, pwdata, num_errors, comparisons} = '0;
		seed = 22678;
		nak = 1'($random(seed));
		dat = 8'($random(seed));
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		for (int i = 0; i < 6; i++) rd(ra[i], {24'h0, rv[i]});
		apb(1'b0, 8'h20, 32'h0);
		chk({31'h0, rerr}, 32'h1);
		apb(1'b1, ADR_MASK, 32'hFF);
		rd(ADR_MASK, 32'hFE);
		apb(1'b1, ADR_DATA, 32'h55);
		rd(ADR_CTRL, 32'h08);
		apb(1'b1, ADR_EVTMSK, 32'h2);
		irqchk(1'b1);
		apb(1'b1, ADR_EVT, 32'h2);
		irqchk(1'b0);
		apb(1'b1, ADR_GIE, 32'h1);
		exp_q = '{{CODE_START, 3'h0}, {CODE_AW_ACK, 3'h0},
			nak ? {CODE_DW_NAK, 3'h0} : {CODE_DW_ACK, 3'h0},
			{CODE_RSTART, 3'h0}, {CODE_AW_NAK, 3'h0}};
		step(8'hA5);
		irqchk(1'b1);
		apb(1'b1, ADR_GIE, 32'h0);
		irqchk(1'b0);
		apb(1'b1, ADR_GIE, 32'h1);
		apb(1'b1, ADR_DATA, {24'h0, SADR, 1'b0});
		rd(ADR_CTRL, 32'hA5);
		step(8'h85);
		apb(1'b1, ADR_DATA, {24'h0, dat});
		step(8'h85);
		chk({24'h0, i_twah_slave_model.sh}, {24'h0, dat});
		step(8'hA5);
		apb(1'b1, ADR_DATA, {24'h0, ~SADR, 1'b0});
		step(8'h85);
		apb(1'b1, ADR_CTRL, 32'h95);
		repeat (300) @(posedge ref_clk);
		rd(ADR_CTRL, 32'h05);
		rd(ADR_EVT, 32'h05);
		chk({30'h0, scl_w, sda_w}, 32'h3);
		for (int t = 0; t < 3; t++) begin
			own = {1'b1, 6'($random(seed))};
			msk = 7'($random(seed)) & 7'h3E;
			hit = own ^ (7'($random(seed)) & msk);
			apb(1'b1, ADR_OWN, {24'h0, own, 1'b0});
			apb(1'b1, ADR_MASK, {24'h0, msk, 1'b0});
			apb(1'b1, ADR_CTRL, 32'h44);
			for (int m = 0; m < 2; m++) begin
				bang({hit ^ 7'(m), 1'b0}, ack);
				chk({31'h0, ack}, 32'(m == 0));
				rd(ADR_CTRL, (m == 0) ? 32'hC4 : 32'h44);
				if (m == 0) rd(ADR_STATUS, {24'h0, CODE_SW_OWN, 3'h0});
				if (m == 0) irqchk(1'b0);
				apb(1'b1, ADR_CTRL, 32'hC4);
				rd(ADR_CTRL, 32'h44);
				stopb;
			end
		end
		test_done;
	end
endmodule : test_twah_top
`default_nettype wire
